// ===== hw/interrupt_controller_unit.sv
// How it works
// - Field value 00 keeps its source disabled; no request reaches the core.
// - Field 01 gives level 0, 10 gives level 1, 11 gives level 2.
// - No encoding yields a level above two.
// - All priority fields read zero after reset, every source disabled.
// - Reserved bits read zero and ignore writes in all three registers.
// - Index 2 bits 15:10 hold the three flash interrupt priorities.
// - Index 2 bits 9:8 PLL unlock, bits 7:6 low-voltage priority.
// - Index 2 bits 3:2 external pin B, bits 1:0 pin A priority.
// - Index 3 bits 15:10 hold GPIO port D, E, F priorities.
// - Index 3 bits 9:8 CAN message buffer, bits 7:6 CAN wake-up.
// - Index 3 bits 5:4 CAN error, bits 3:2 CAN bus-off.
// - Index 4 bits 15:10 hold SPI0 rx, SPI1 tx, SPI1 rx priorities.
// - Index 4 bits 5:0 hold GPIO port A, B, C priorities.
// - In low power, wake only for sources enabled before entry.
// - In low power, both external pins act low-level sensitive.
// - Each register sits at base index plus its own index.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module interrupt_controller_unit #(
  parameter logic [29:0] BASE = irq_prio_pkg::BASE_INDEX
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [17:0] periph_req,
  input  wire logic        ext_interrupt_pin_a_n,
  input  wire logic        ext_interrupt_pin_b_n,
  input  wire logic        low_power,
  output logic [19:0]      core_req,
  output logic [39:0]      core_level,
  output logic             wake_req,
  output logic             irq
);

  // ===========================================================
  // Helper functions
  // ===========================================================
  // Gather the twenty 2-bit fields, source 0 in the low bits
  function automatic logic [39:0] fields_of(input logic [15:0] p2,
                                            input logic [15:0] p3,
                                            input logic [15:0] p4);
    fields_of = {p4[15:10], p4[5:0],
                 p3[15:10], p3[9:2],
                 p2[15:10], p2[9:6],
                 p2[3:0]};
  endfunction

  // One field to a level; disabled fields give level 0 but no enable
  function automatic logic [1:0] level_of(input logic [1:0] f);
    case (f)
      irq_prio_pkg::FIELD_LVL0: level_of = irq_prio_pkg::LEVEL_0;
      irq_prio_pkg::FIELD_LVL1: level_of = irq_prio_pkg::LEVEL_1;
      irq_prio_pkg::FIELD_LVL2: level_of = irq_prio_pkg::LEVEL_2;
      default:                  level_of = irq_prio_pkg::LEVEL_0;
    endcase
  endfunction

  function automatic logic [19:0] enables_of(input logic [39:0] fv);
    logic [19:0] e;
    e = '0;
    for (int i = 0; i < irq_prio_pkg::NUM_SRC; i++) begin
      e[i] = (fv[2*i +: 2] != irq_prio_pkg::FIELD_OFF);
    end
    enables_of = e;
  endfunction

  function automatic logic [39:0] levels_of(input logic [39:0] fv);
    logic [39:0] l;
    l = '0;
    for (int i = 0; i < irq_prio_pkg::NUM_SRC; i++) begin
      l[2*i +: 2] = level_of(fv[2*i +: 2]);
    end
    levels_of = l;
  endfunction

  // ===========================================================
  // State
  // ===========================================================
  irq_prio_pkg::state_t s;
  irq_prio_pkg::state_t next_s;

  logic [39:0] fields;
  logic [19:0] enables;
  logic [19:0] raw_req;
  logic [19:0] gated_req;
  logic        pin_a_low;
  logic        pin_b_low;
  logic        pin_a_fall;
  logic        pin_b_fall;
  logic        access;
  logic        done;
  logic [29:0] word;
  logic        hit_p2;
  logic        hit_p3;
  logic        hit_p4;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        hit_mask;
  logic        hit_any;

  // ===========================================================
  // Request sources
  // ===========================================================
  // Pins are read only after the second synchroniser stage
  assign pin_a_low  = ~s.pin_a_sync[1];
  assign pin_b_low  = ~s.pin_b_sync[1];
  assign pin_a_fall = s.pin_a_prev & ~s.pin_a_sync[1];
  assign pin_b_fall = s.pin_b_prev & ~s.pin_b_sync[1];

  // No clock edge to see in low power, so fall back to level
  always_comb begin
    raw_req       = {periph_req, 2'b00};
    raw_req[0]    = (s.ctrl[irq_prio_pkg::CTRL_PIN_A_EDGE] && !low_power)
                    ? pin_a_fall : pin_a_low;
    raw_req[1]    = (s.ctrl[irq_prio_pkg::CTRL_PIN_B_EDGE] && !low_power)
                    ? pin_b_fall : pin_b_low;
  end

  assign fields    = fields_of(s.flash_power_pin_irq_priority,
                               s.gpio_can_irq_priority,
                               s.serial_gpio_irq_priority);
  assign enables   = enables_of(fields);
  assign gated_req = raw_req & enables;

  // ===========================================================
  // APB decode: one wait state, answer registered
  // ===========================================================
  assign access   = psel & penable;
  assign done     = access & s.pready;
  assign word     = paddr[31:2];
  assign hit_p2   = (word == BASE + irq_prio_pkg::IDX_FLASH_PWR);
  assign hit_p3   = (word == BASE + irq_prio_pkg::IDX_GPIO_CAN);
  assign hit_p4   = (word == BASE + irq_prio_pkg::IDX_SERIAL_GPIO);
  assign hit_ctrl = (word == BASE + irq_prio_pkg::IDX_CTRL);
  assign hit_stat = (word == BASE + irq_prio_pkg::IDX_STATUS);
  assign hit_mask = (word == BASE + irq_prio_pkg::IDX_MASK);
  assign hit_any  = hit_p2 | hit_p3 | hit_p4 | hit_ctrl | hit_stat
                    | hit_mask;

  // ===========================================================
  // Next state
  // ===========================================================
  always_comb begin
    logic [31:0] rd;
    logic [31:0] wd;
    logic        wr;
    rd = '0;
    wd = pwdata;
    wr = done & pwrite & hit_any;
    next_s = s;

    // Synchronisers and edge history
    next_s.pin_a_sync     = {s.pin_a_sync[0], ext_interrupt_pin_a_n};
    next_s.pin_b_sync     = {s.pin_b_sync[0], ext_interrupt_pin_b_n};
    next_s.pin_a_prev     = s.pin_a_sync[1];
    next_s.pin_b_prev     = s.pin_b_sync[1];
    next_s.low_power_prev = low_power;

    // Strobes 0 and 1 each gate one low byte, zeroing it when clear; strobes 2 and 3 are ignored
    if (!pstrb[0]) begin
      wd[7:0] = 8'h00;
    end
    if (!pstrb[1]) begin
      wd[15:8] = 8'h00;
    end

    // Bus slave: raise pready for one cycle, then complete
    next_s.pready  = access & ~s.pready;
    next_s.pslverr = access & ~s.pready & ~hit_any;
    if (hit_p2) begin
      rd = {16'h0000, s.flash_power_pin_irq_priority};
    end else if (hit_p3) begin
      rd = {16'h0000, s.gpio_can_irq_priority};
    end else if (hit_p4) begin
      rd = {16'h0000, s.serial_gpio_irq_priority};
    end else if (hit_ctrl) begin
      rd = {30'h0, s.ctrl};
    end else if (hit_stat) begin
      rd = {12'h000, s.status};
    end else if (hit_mask) begin
      rd = {12'h000, s.mask};
    end
    next_s.prdata = (access & ~s.pready & ~pwrite) ? rd : 32'h0000_0000;

    // Register writes, reserved bits never stored
    if (wr && hit_p2) begin
      next_s.flash_power_pin_irq_priority =
        wd[15:0] & irq_prio_pkg::WMASK_FLASH;
    end
    if (wr && hit_p3) begin
      next_s.gpio_can_irq_priority =
        wd[15:0] & irq_prio_pkg::WMASK_GPIO_CAN;
    end
    if (wr && hit_p4) begin
      next_s.serial_gpio_irq_priority =
        wd[15:0] & irq_prio_pkg::WMASK_SERIAL;
    end
    if (wr && hit_ctrl) begin
      next_s.ctrl = wd[1:0];
    end
    if (wr && hit_mask) begin
      next_s.mask = wd[19:0];
    end

    // New requests set sticky status; a set beats a same-cycle clear
    next_s.status = s.status;
    if (wr && hit_stat) begin
      next_s.status = s.status & ~wd[19:0];
    end
    next_s.status = next_s.status | (gated_req & ~s.core_req);

    // Core sees enabled requests and levels one cycle later
    next_s.core_req   = gated_req;
    next_s.core_level = levels_of(fields);

    // Enables are frozen at entry to low power
    if (low_power && !s.low_power_prev) begin
      next_s.armed = enables;
    end
    next_s.wake = low_power &&
      |(raw_req & ((low_power && !s.low_power_prev) ? enables
                                                     : s.armed));

    next_s.irq = |(next_s.status & next_s.mask);
  end

  // ===========================================================
  // Registers
  // ===========================================================
  // All priority fields clear, so every source starts disabled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.flash_power_pin_irq_priority <= irq_prio_pkg::PRIO_RESET;
      s.gpio_can_irq_priority        <= irq_prio_pkg::PRIO_RESET;
      s.serial_gpio_irq_priority     <= irq_prio_pkg::PRIO_RESET;
      s.pin_a_sync <= 2'b11;
      s.pin_b_sync <= 2'b11;
      s.pin_a_prev <= 1'b1;
      s.pin_b_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign pready     = s.pready;
  assign prdata     = s.prdata;
  assign pslverr    = s.pslverr;
  assign core_req   = s.core_req;
  assign core_level = s.core_level;
  assign wake_req   = s.wake;
  assign irq        = s.irq;

  // ===========================================================
  // Assertions
  // ===========================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Reference map from the raw fields, kept apart from level_of
  logic [19:0] lvl_is_three;
  logic [19:0] field_off;
  logic [39:0] exp_level;
  always_comb begin
    lvl_is_three = '0;
    field_off    = '0;
    exp_level    = '0;
    for (int i = 0; i < irq_prio_pkg::NUM_SRC; i++) begin
      lvl_is_three[i] = (s.core_level[2*i +: 2] == 2'h3);
      field_off[i]    = (fields[2*i +: 2] == irq_prio_pkg::FIELD_OFF);
      exp_level[2*i +: 2] =
        (fields[2*i +: 2] == irq_prio_pkg::FIELD_OFF) ? 2'h0
                                                      : fields[2*i +: 2] - 2'h1;
    end
  end

  a_disabled_quiet: assert property (
    (core_req & $past(field_off)) == 20'h00000)
    else $error("request from disabled source");

  a_level_map: assert property (
    core_level == $past(exp_level))
    else $error("level does not follow field");

  a_level_range: assert property (
    lvl_is_three == 20'h00000)
    else $error("level above two");

  a_reset_clear: assert property (disable iff (1'b0)
    $rose(reset_n) |-> (fields == 40'h0 && core_req == 20'h00000))
    else $error("fields not clear after reset");

  a_reserved_zero: assert property (
    (s.flash_power_pin_irq_priority & ~irq_prio_pkg::WMASK_FLASH) == 0 &&
    (s.gpio_can_irq_priority & ~irq_prio_pkg::WMASK_GPIO_CAN) == 0 &&
    (s.serial_gpio_irq_priority & ~irq_prio_pkg::WMASK_SERIAL) == 0)
    else $error("reserved bit set");

  a_flash_read: assert property (
    (access && !s.pready && !pwrite && hit_p2) |=>
      (pready && prdata[15:0] == $past(s.flash_power_pin_irq_priority)))
    else $error("bad read of flash register");

  a_write_decode: assert property (
    (done && pwrite && hit_p3 && pstrb == 4'hF) |=>
      s.gpio_can_irq_priority ==
        ($past(pwdata[15:0]) & irq_prio_pkg::WMASK_GPIO_CAN))
    else $error("write missed decoded register");

  a_pin_level_lp: assert property (
    (low_power && pin_a_low && enables[0]) |=> core_req[0])
    else $error("pin A not level sensitive");

  a_wake_armed: assert property (
    wake_req |-> ($past(low_power) &&
                  |($past(raw_req) & (s.armed | $past(enables))))
    ) else $error("wake without armed source");

  a_irq_level: assert property (
    irq == |(s.status & s.mask))
    else $error("interrupt output mismatch");

  a_unmapped_error: assert property (
    (access && !s.pready && !hit_any) |=> (pslverr && prdata == 32'h0))
    else $error("unmapped access not refused");

  c_write_then_req: cover property (
    (done && pwrite && hit_p2) ##[1:4] core_req[0]);
  c_wake_seen: cover property ($rose(low_power) ##[1:8] wake_req);
  c_bad_addr: cover property (done && pslverr);
  c_status_irq: cover property ($rose(irq));
  c_top_level: cover property (
    core_req[0] && core_level[1:0] == irq_prio_pkg::LEVEL_2);

endmodule

`default_nettype wire

// ===== hw/irq_prio_pkg.sv
package irq_prio_pkg;

  // ===========================================================
  // Register indexes (byte address = 4 * (base index + index))
  // ===========================================================
  localparam logic [29:0] BASE_INDEX      = 30'h000F1A0;
  localparam logic [29:0] IDX_FLASH_PWR   = 30'h0000002;
  localparam logic [29:0] IDX_GPIO_CAN    = 30'h0000003;
  localparam logic [29:0] IDX_SERIAL_GPIO = 30'h0000004;
  localparam logic [29:0] IDX_CTRL        = 30'h0000020;
  localparam logic [29:0] IDX_STATUS      = 30'h0000021;
  localparam logic [29:0] IDX_MASK        = 30'h0000022;

  // ===========================================================
  // Field layouts and reset values
  // ===========================================================
  localparam int          NUM_SRC        = 20;
  localparam logic [15:0] WMASK_FLASH    = 16'hFFCF;
  localparam logic [15:0] WMASK_GPIO_CAN = 16'hFFFC;
  localparam logic [15:0] WMASK_SERIAL   = 16'hFC3F;
  localparam logic [15:0] PRIO_RESET     = 16'h0000;
  localparam int          CTRL_PIN_A_EDGE = 0;
  localparam int          CTRL_PIN_B_EDGE = 1;
  localparam logic [1:0]  FIELD_OFF      = 2'h0;
  localparam logic [1:0]  FIELD_LVL0     = 2'h1;
  localparam logic [1:0]  FIELD_LVL1     = 2'h2;
  localparam logic [1:0]  FIELD_LVL2     = 2'h3;
  localparam logic [1:0]  LEVEL_0        = 2'h0;
  localparam logic [1:0]  LEVEL_1        = 2'h1;
  localparam logic [1:0]  LEVEL_2        = 2'h2;

  // ===========================================================
  // Whole state of the block
  // ===========================================================
  typedef struct packed {
    logic [15:0] flash_power_pin_irq_priority;
    logic [15:0] gpio_can_irq_priority;
    logic [15:0] serial_gpio_irq_priority;
    logic [1:0]  ctrl;
    logic [19:0] status;
    logic [19:0] mask;
    logic [1:0]  pin_a_sync;
    logic [1:0]  pin_b_sync;
    logic        pin_a_prev;
    logic        pin_b_prev;
    logic        low_power_prev;
    logic [19:0] armed;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [19:0] core_req;
    logic [39:0] core_level;
    logic        wake;
    logic        irq;
  } state_t;

endpackage

// ===== sim/core_model.sv
`timescale 1ns/1ps
`default_nettype none

module core_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [19:0] core_req,
  input  wire logic [39:0] core_level,
  output logic [1:0]       best_level,
  output logic             has_req
);
  // ===========================================================
  // Highest level among live requests
  // ===========================================================
  function automatic logic [1:0] top(input logic [19:0] req,
                                     input logic [39:0] lvl);
    logic [1:0] b;
    b = 2'h0;
    for (int k = 0; k < 20; k++) begin
      if (req[k] && lvl[2*k +: 2] > b) begin
        b = lvl[2*k +: 2];
      end
    end
    return b;
  endfunction

  // Core samples once per edge, so it lags the outputs by one cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      best_level <= 2'h0;
      has_req    <= 1'b0;
    end else begin
      best_level <= top(core_req, core_level);
      has_req    <= |core_req;
    end
  end
endmodule
`default_nettype wire

// ===== sim/irq_priority_config_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none

module irq_priority_config_regs_bench;
  // ===========================================================
  // Stimulus, observation and design hookup
  // ===========================================================
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [17:0] periph_req = 18'h0;
  logic        pin_a_n = 1'b1;
  logic        pin_b_n = 1'b1;
  logic        low_power = 1'b0;
  logic        pready, pslverr, wake_req, irq, has_req, last_err;
  logic [31:0] prdata;
  logic [19:0] core_req;
  logic [39:0] core_level;
  logic [1:0]  best_level;
  int          errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  localparam int POS [20] = '{0, 2, 6, 8, 10, 12, 14, 2, 4, 6, 8, 10, 12,
                              14, 0, 2, 4, 10, 12, 14};
  localparam logic [15:0] WM [3] = '{16'hFFCF, 16'hFFFC, 16'hFC3F};

  always #20 clk = ~clk;

  interrupt_controller_unit u_dut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .periph_req(periph_req), .ext_interrupt_pin_a_n(pin_a_n),
    .ext_interrupt_pin_b_n(pin_b_n), .low_power(low_power),
    .core_req(core_req), .core_level(core_level), .wake_req(wake_req),
    .irq(irq));

  core_model u_core (
    .clk(clk), .reset_n(reset_n), .core_req(core_req),
    .core_level(core_level), .best_level(best_level), .has_req(has_req));

  // ===========================================================
  // Shared tasks
  // ===========================================================
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // One APB transfer; an idle cycle follows so psel never toggles twice
  task automatic apb(input logic wr, input logic [29:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {irq_prio_pkg::BASE_INDEX + idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // No cycle count assumed; only the hang guard ends a stuck wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic give_verdict();
    $display("Compares %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard, far above the five hundred or so cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end

  // ===========================================================
  // Test sequence
  // ===========================================================
  initial begin
    logic [31:0] rd;
    logic [15:0] v;
    int          r;
    int          i;
    int          c;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (r = 2; r < 5; r++) begin
      apb(1'b0, 30'(r), 32'h0, rd);
      check(rd, 40'h0);
    end
    $display("Test done: reset values");
    // Every source requesting, so only the fields gate the core
    periph_req <= 18'h3FFFF;
    pin_a_n <= 1'b0;
    pin_b_n <= 1'b0;
    for (c = 0; c < 4; c++) begin
      v = {8{2'(c)}};
      for (r = 2; r < 5; r++) begin
        apb(1'b1, 30'(r), {16'h0, v}, rd);
      end
      repeat (2) @(posedge clk);
      check(core_req, (c == 0) ? 40'h0 : 40'hFFFFF);
      check(core_level, (c == 0) ? 40'h0 : {20{2'(c - 1)}});
      check(has_req, (c == 0) ? 40'h0 : 40'h1);
      for (r = 2; r < 5; r++) begin
        apb(1'b0, 30'(r), 32'h0, rd);
        check(rd, {24'h0, v & WM[r - 2]});
      end
    end
    $display("Test done: codes and reserved bits");
    // One field at a time proves each source sits in its own bits
    for (i = 0; i < 20; i++) begin
      c = i % 3 + 1;
      for (r = 2; r < 5; r++) begin
        v = (r == ((i < 7) ? 2 : (i < 14) ? 3 : 4)) ? 16'(c << POS[i]) : 16'h0;
        apb(1'b1, 30'(r), {16'h0, v}, rd);
      end
      repeat (3) @(posedge clk);
      check(core_req, 40'(20'h1 << i));
      check(core_level, 40'(c - 1) << (2 * i));
      check(best_level, 40'(c - 1));
      check(has_req, 40'h1);
    end
    $display("Test done: field placement");
    apb(1'b0, irq_prio_pkg::IDX_STATUS, 32'h0, rd);
    check(rd, 40'hFFFFF);
    check(irq, 40'h0);
    apb(1'b1, irq_prio_pkg::IDX_MASK, 32'h1, rd);
    repeat (2) @(posedge clk);
    check(irq, 40'h1);
    apb(1'b1, irq_prio_pkg::IDX_STATUS, 32'hFFFFF, rd);
    repeat (2) @(posedge clk);
    check(irq, 40'h0);
    apb(1'b0, 30'h5, 32'h0, rd);
    check({last_err, rd}, 40'h100000000);
    $display("Test done: interrupt and unmapped");
    // Only sources enabled before low power may wake the device
    periph_req <= 18'h0;
    pin_a_n <= 1'b1;
    pin_b_n <= 1'b1;
    apb(1'b1, 30'h2, 32'h0040, rd);
    apb(1'b1, 30'h4, 32'h0, rd);
    low_power <= 1'b1;
    apb(1'b1, 30'h3, 32'h0100, rd);
    periph_req <= 18'h00100;
    repeat (3) @(posedge clk);
    check(wake_req, 40'h0);
    periph_req <= 18'h00101;
    repeat (3) @(posedge clk);
    check(wake_req, 40'h1);
    low_power <= 1'b0;
    periph_req <= 18'h0;
    apb(1'b1, irq_prio_pkg::IDX_CTRL, 32'h3, rd);
    apb(1'b1, 30'h2, 32'h0001, rd);
    low_power <= 1'b1;
    pin_a_n <= 1'b0;
    repeat (10) @(posedge clk);
    check(wake_req, 40'h1);
    $display("Test done: low power wake");
    // Reset in mid-run must clear the fields programmed above
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check(core_req, 40'h0);
    apb(1'b0, 30'h2, 32'h0, rd);
    check(rd, 40'h0);
    $display("Test done: reset mid-run");
    give_verdict();
  end
endmodule
`default_nettype wire
